// >>> logic/msd_decode.sv
/*
  msd_decode: instruction pointer, data address decode, byte lanes, trap.
  assumes the core drives requests on sys_clk and the rams answer combinationally.
*/
// Functional notes
// - program word pairs: lower word even address, upper odd, top byte unused.
// - instruction pointer stays even and steps by two per word.
// - vectors reserved below 0x200; reset starts at 0x000000, target at 0x000002.
// - primary vector table 0x04-0xff, alternate table 0x100-0x1ff.
// - data addresses are 16-bit byte addresses, 64 kilobytes total.
// - top address bit zero selects ram, one selects program visibility window.
// - up to 30 kilobytes ram; reads outside it return zero.
// - low byte at even address, high byte at odd address.
// - pointer updates step one for bytes, two for words.
// - byte read fetches word, bit 0 picks byte, placed on low byte.
// - shared word decode, per-lane write strobes, byte write hits one lane.
// - word access to odd address raises address error trap.
// - misaligned read completes, misaligned write suppressed, trap follows.
// - byte load into working register changes only its low byte.
// - sign extend byte to word, zero extend clears upper byte.
// - 0x0000-0x07ff holds control registers; unused ones read zero.
// - near space 0x0000-0x1fff reached by 13-bit direct field.
// - x and y spaces with own generators allow two reads per cycle.
// - x has separate read and write buses; x read serves combined space.
// - y read path used only by dual operand dsp class.
// - circular addressing in x and y; bit reversal only on x writes.
// - all writes use combined map; x/y boundary is fixed.
`timescale 1ns/100ps
module msd_decode import msd_pkg::*; #(
  parameter logic [15:0] RAM_END = MSD_RAM_END_DEF,
  parameter logic [15:0] XY_BOUNDARY = MSD_XY_BOUNDARY_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // program side
  input wire logic ip_advance,
  input wire logic ip_retreat,
  input wire logic ip_load,
  input wire logic [23:0] ip_load_addr,
  input wire logic [23:0] prog_fetch_addr,
  output logic [23:0] instruction_pointer,
  output logic [23:0] prog_word_addr,
  output logic prog_upper_sel,
  output logic in_vector_area,
  output logic in_primary_table,
  output logic in_alternate_table,
  // x space request and pointer update
  input wire msd_req_t x_req,
  input wire msd_ptr_mode_t x_ptr_mode,
  input wire logic [15:0] source_pointer_register,
  input wire msd_ptr_cfg_t x_cfg,
  input wire logic [12:0] near_direct_field,
  input wire logic near_direct_sel,
  // y space request, dual operand dsp class only
  input wire logic dual_operand_dsp_class,
  input wire logic y_rd_valid,
  input wire logic [15:0] y_rd_addr,
  input wire msd_ptr_mode_t y_ptr_mode,
  input wire logic [15:0] y_pointer,
  input wire msd_ptr_cfg_t y_cfg,
  // working register load shaping
  input wire msd_ext_t ext_op,
  input wire logic [15:0] wreg_old,
  // memory side
  input wire logic [15:0] ram_rdata,
  input wire logic [15:0] y_ram_rdata,
  input wire logic [15:0] pcr_rdata,
  input wire logic pcr_hit,
  input wire logic [15:0] psv_rdata,
  output logic [14:0] ram_word_addr,
  output logic [1:0] ram_lane_we,
  output logic [15:0] ram_wdata,
  output logic pcr_sel,
  output logic psv_sel,
  output logic [14:0] y_ram_word_addr,
  // results
  output logic [15:0] x_rdata,
  output logic [15:0] y_rdata,
  output logic [15:0] wreg_new,
  output logic [15:0] x_ptr_next,
  output logic [15:0] y_ptr_next,
  output logic in_near_space,
  output logic x_space_hit,
  output logic address_error_trap
);
  initial begin
    if (RAM_END[15] || RAM_END < MSD_PCR_END) $error("msd: bad ram end");
    if (XY_BOUNDARY > RAM_END) $error("msd: bad x/y boundary");
  end

  // step size scaled to access width
  function automatic logic [15:0] msd_step(input logic byte_op);
    msd_step = byte_op ? MSD_STEP_BYTE : MSD_STEP_WORD;
  endfunction : msd_step

  // implemented ram window, below the visibility half
  function automatic logic msd_is_ram(input logic [15:0] addr);
    msd_is_ram = !addr[MSD_PSV_BIT] && addr <= RAM_END;
  endfunction : msd_is_ram

  // control register area at the bottom of the near space
  function automatic logic msd_is_pcr(input logic [15:0] addr);
    msd_is_pcr = !addr[MSD_PSV_BIT] && addr <= MSD_PCR_END;
  endfunction : msd_is_pcr

  // near space reachable by the short direct field
  function automatic logic msd_is_near(input logic [15:0] addr);
    msd_is_near = !addr[MSD_PSV_BIT] && addr <= MSD_NEAR_END;
  endfunction : msd_is_near

  // y read window, from the fixed boundary up to the ram end
  function automatic logic msd_is_y(input logic [15:0] addr);
    msd_is_y = !addr[MSD_PSV_BIT] && addr >= XY_BOUNDARY && addr <= RAM_END;
  endfunction : msd_is_y

  // program address inside an inclusive range
  function automatic logic msd_in_range(input logic [23:0] addr, input logic [23:0] lo,
                                        input logic [23:0] hi);
    msd_in_range = addr >= lo && addr <= hi;
  endfunction : msd_in_range

  // pointer update with circular wrap and optional bit reversal
  function automatic logic [15:0] msd_ptr(input logic [15:0] p, input msd_ptr_mode_t m,
                                          input logic byte_op, input msd_ptr_cfg_t c,
                                          input logic allow_rev);
    logic [15:0] s;
    logic [15:0] r;
    s = msd_step(byte_op);
    r = p;
    if (allow_rev && c.bitrev_en && m == MSD_PTR_INC) begin
      for (int i = 15; i >= 0; i--) begin
        if (c.bitrev_mod[i]) begin
          r[i] = ~r[i];
          if (r[i]) break;
        end
      end
    end else if (m == MSD_PTR_INC) begin
      r = p + s;
      if (c.circ_en && p >= c.circ_end - s + 16'h0001) r = c.circ_start;
    end else if (m == MSD_PTR_DEC) begin
      r = p - s;
      if (c.circ_en && p == c.circ_start) r = c.circ_end - s + 16'h0001;
    end
    msd_ptr = r;
  endfunction : msd_ptr

  // instruction pointer state
  logic [23:0] next_instruction_pointer;
  always_comb begin
    next_instruction_pointer = instruction_pointer;
    if (ip_load) next_instruction_pointer = {ip_load_addr[23:1], 1'b0};
    else if (ip_advance) next_instruction_pointer = instruction_pointer + MSD_IP_STEP;
    else if (ip_retreat) next_instruction_pointer = instruction_pointer - MSD_IP_STEP;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) instruction_pointer <= MSD_RESET_ADDR;
    else if (clk_en) instruction_pointer <= next_instruction_pointer;
  end

  // data decode, combinational part
  logic [15:0] ea;
  logic misaligned;
  logic in_ram;
  logic [15:0] word_rd;
  logic [15:0] next_x_rdata;
  logic [15:0] next_y_rdata;
  logic [15:0] next_wreg;
  logic [1:0] next_lane_we;
  logic [15:0] next_wdata;
  logic [7:0] sel_byte;
  logic next_pcr_sel;
  logic next_psv_sel;
  logic [15:0] next_x_ptr;
  logic [15:0] next_y_ptr;
  logic next_near;
  logic next_x_hit;
  always_comb begin
    ea = near_direct_sel ? {3'b000, near_direct_field} : x_req.operand_byte_address;
    misaligned = x_req.valid && !x_req.byte_op && ea[0];
    in_ram = msd_is_ram(ea);
    // control register area reads zero where no register answers
    if (ea[MSD_PSV_BIT]) word_rd = psv_rdata;
    else if (ea <= MSD_PCR_END) word_rd = pcr_hit ? pcr_rdata : MSD_RESET_WORD;
    else if (in_ram) word_rd = ram_rdata;
    else word_rd = MSD_RESET_WORD;
    sel_byte = ea[0] ? word_rd[15:8] : word_rd[7:0];
    next_x_rdata = x_req.byte_op ? {8'h00, sel_byte} : word_rd;
    // y path only returns data for the dual operand class
    next_y_rdata = MSD_RESET_WORD;
    // other classes see zero so a stale y word never leaks into x results
    if (dual_operand_dsp_class && y_rd_valid && msd_is_y(y_rd_addr)) begin
      next_y_rdata = y_ram_rdata;
    end
    // lane strobes, gated by the alignment check before they leave
    next_lane_we = 2'b00;
    // a misaligned word write must never reach the array, hence the gate here
    if (x_req.valid && x_req.write && !misaligned && in_ram) begin
      if (x_req.byte_op) next_lane_we = ea[0] ? 2'b10 : 2'b01;
      else next_lane_we = 2'b11;
    end
    next_wdata = x_req.byte_op ? {x_req.wdata[7:0], x_req.wdata[7:0]} : x_req.wdata;
    // working register load shaping
    unique case (ext_op)
      MSD_EXT_SIGN: next_wreg = {{8{wreg_old[7]}}, wreg_old[7:0]};
      MSD_EXT_ZERO: next_wreg = {8'h00, wreg_old[7:0]};
      default: next_wreg = x_req.byte_op ? {wreg_old[15:8], next_x_rdata[7:0]}
                                         : next_x_rdata;
    endcase
    // side selects and region flags
    next_pcr_sel = x_req.valid && msd_is_pcr(ea);
    next_psv_sel = x_req.valid && ea[MSD_PSV_BIT];
    next_near = msd_is_near(ea);
    next_x_hit = in_ram && ea < XY_BOUNDARY;
    // bit reversal is only offered on the write pointer of x
    next_x_ptr = msd_ptr(source_pointer_register, x_ptr_mode, x_req.byte_op, x_cfg,
                         x_req.write);
    // y always moves in words and is never bit reversed
    next_y_ptr = msd_ptr(y_pointer, y_ptr_mode, 1'b0, y_cfg, 1'b0);
  end

  // registered data side outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ram_word_addr <= 15'h0000;
      ram_lane_we <= 2'b00;
      ram_wdata <= MSD_RESET_WORD;
      pcr_sel <= 1'b0;
      psv_sel <= 1'b0;
      y_ram_word_addr <= 15'h0000;
      x_rdata <= MSD_RESET_WORD;
      y_rdata <= MSD_RESET_WORD;
      wreg_new <= MSD_RESET_WORD;
      x_ptr_next <= MSD_RESET_WORD;
      y_ptr_next <= MSD_RESET_WORD;
      in_near_space <= 1'b0;
      x_space_hit <= 1'b0;
      address_error_trap <= 1'b0;
    end else if (clk_en) begin
      ram_word_addr <= ea[15:1];
      ram_lane_we <= next_lane_we;
      ram_wdata <= next_wdata;
      pcr_sel <= next_pcr_sel;
      psv_sel <= next_psv_sel;
      y_ram_word_addr <= y_rd_addr[15:1];
      x_rdata <= next_x_rdata;
      y_rdata <= next_y_rdata;
      wreg_new <= next_wreg;
      x_ptr_next <= next_x_ptr;
      y_ptr_next <= next_y_ptr;
      in_near_space <= next_near;
      x_space_hit <= next_x_hit;
      address_error_trap <= misaligned;
    end
  end

  // program space decode
  logic [23:0] next_prog_word_addr;
  logic next_prog_upper_sel;
  logic next_in_vector_area;
  logic next_in_primary_table;
  logic next_in_alternate_table;
  always_comb begin
    next_prog_word_addr = {prog_fetch_addr[23:1], 1'b0};
    next_prog_upper_sel = prog_fetch_addr[0];
    // vector flags let the fetch side tell table entries from code
    next_in_vector_area = prog_fetch_addr < MSD_VECTOR_END;
    next_in_primary_table = msd_in_range(prog_fetch_addr, MSD_IVT_BASE, MSD_IVT_END);
    next_in_alternate_table = msd_in_range(prog_fetch_addr, MSD_AIVT_BASE,
                                           MSD_AIVT_END);
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prog_word_addr <= MSD_RESET_ADDR;
      prog_upper_sel <= 1'b0;
      in_vector_area <= 1'b0;
      in_primary_table <= 1'b0;
      in_alternate_table <= 1'b0;
    end else if (clk_en) begin
      prog_word_addr <= next_prog_word_addr;
      prog_upper_sel <= next_prog_upper_sel;
      in_vector_area <= next_in_vector_area;
      in_primary_table <= next_in_primary_table;
      in_alternate_table <= next_in_alternate_table;
    end
  end
endmodule : msd_decode

// >>> logic/msd_pkg.sv
/*
  msd_pkg: constants and carriers for the memory space address decode block.
  assumes a 16-bit byte-addressed data space and a 24-bit program space.
*/
package msd_pkg;
  // program space layout
  localparam logic [23:0] MSD_RESET_ADDR = 24'h000000;
  localparam logic [23:0] MSD_RESET_TARGET = 24'h000002;
  localparam logic [23:0] MSD_IVT_BASE = 24'h000004;
  localparam logic [23:0] MSD_IVT_END = 24'h0000ff;
  localparam logic [23:0] MSD_AIVT_BASE = 24'h000100;
  localparam logic [23:0] MSD_AIVT_END = 24'h0001ff;
  localparam logic [23:0] MSD_VECTOR_END = 24'h000200;
  localparam logic [23:0] MSD_IP_STEP = 24'h000002;
  // data space layout
  localparam logic [15:0] MSD_PCR_END = 16'h07ff;
  localparam logic [15:0] MSD_NEAR_END = 16'h1fff;
  localparam logic [15:0] MSD_RAM_END_DEF = 16'h77ff;
  localparam logic [15:0] MSD_XY_BOUNDARY_DEF = 16'h4800;
  localparam int MSD_PSV_BIT = 15;
  localparam int MSD_NEAR_BITS = 13;
  localparam logic [15:0] MSD_STEP_BYTE = 16'h0001;
  localparam logic [15:0] MSD_STEP_WORD = 16'h0002;
  localparam logic [15:0] MSD_RESET_WORD = 16'h0000;

  // pointer update modes
  typedef enum logic [1:0] {MSD_PTR_HOLD, MSD_PTR_INC, MSD_PTR_DEC} msd_ptr_mode_t;
  // result shaping for a working register load
  typedef enum logic [1:0] {MSD_EXT_NONE, MSD_EXT_SIGN, MSD_EXT_ZERO} msd_ext_t;

  // one data access request from an address generation unit
  typedef struct packed {
    logic valid;
    logic write;
    logic byte_op;
    logic [15:0] operand_byte_address;
    logic [15:0] wdata;
  } msd_req_t;

  // circular and bit-reversed pointer controls
  typedef struct packed {
    logic circ_en;
    logic [15:0] circ_start;
    logic [15:0] circ_end;
    logic bitrev_en;
    logic [15:0] bitrev_mod;
  } msd_ptr_cfg_t;
endpackage : msd_pkg

// >>> test/msd_decode_chk.sv
/*
  msd_decode_chk: port-level checks of the decode block.
  assumes binding onto msd_decode, one clock, sync reset.
*/
`timescale 1ns/100ps
module msd_decode_chk import msd_pkg::*; #(
  parameter logic [15:0] RAM_END = MSD_RAM_END_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic ip_advance,
  input wire logic ip_load,
  input wire logic [23:0] prog_fetch_addr,
  input wire logic [23:0] instruction_pointer,
  input wire logic in_vector_area,
  input wire msd_req_t x_req,
  input wire logic near_direct_sel,
  input wire logic dual_operand_dsp_class,
  input wire logic [14:0] ram_word_addr,
  input wire logic [1:0] ram_lane_we,
  input wire logic psv_sel,
  input wire logic [15:0] x_rdata,
  input wire logic [15:0] y_rdata,
  input wire logic address_error_trap
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [15:0] ea;
  logic [14:0] wa;
  logic [1:0] lane;
  logic go;
  // request fields used below
  assign ea = x_req.operand_byte_address;
  assign wa = ea[15:1];
  assign lane = {ea[0], ~ea[0]};
  assign go = clk_en && x_req.valid && !near_direct_sel;
  AST_TRAP: assert property (go && !x_req.byte_op && ea[0] |=>
    address_error_trap && ram_lane_we == 2'b00) else $error("odd word access not trapped");
  AST_NO_TRAP: assert property (go && (x_req.byte_op || !ea[0]) |=>
    !address_error_trap) else $error("trap without misalignment");
  AST_WADDR: assert property (go |=> ram_word_addr == $past(wa))
    else $error("word address wrong");
  AST_LANE: assert property (go && x_req.write && x_req.byte_op && ea > MSD_PCR_END &&
    ea <= RAM_END |=> ram_lane_we == $past(lane)) else $error("byte lane wrong");
  AST_RD_NO_WE: assert property (go && !x_req.write |=> ram_lane_we == 2'b00)
    else $error("strobe on read");
  AST_PSV: assert property (go && ea[15] |=> psv_sel && ram_lane_we == 2'b00)
    else $error("window access wrong");
  AST_BYTE_RD: assert property (go && !x_req.write && x_req.byte_op |=>
    x_rdata[15:8] == 8'h00) else $error("byte read high byte set");
  AST_IP_EVEN: assert property (instruction_pointer[0] == 1'b0)
    else $error("pointer odd");
  AST_IP_STEP: assert property (clk_en && ip_advance && !ip_load |=>
    instruction_pointer == $past(instruction_pointer) + 24'h000002) else $error("ip step");
  AST_VEC: assert property (clk_en |=> in_vector_area == ($past(prog_fetch_addr) < 24'h000200))
    else $error("vector area flag");
  AST_Y: assert property (clk_en && !dual_operand_dsp_class |=> y_rdata == 16'h0000)
    else $error("y path outside dsp class");
endmodule : msd_decode_chk

// >>> test/msd_mem_model.sv
/*
  msd_mem_model: data ram behind the decode block, two byte lanes.
  assumes the read address is shown in the request cycle.
*/
`timescale 1ns/100ps
module msd_mem_model (
  input wire logic sys_clk,
  input wire logic [15:0] rd_addr,
  input wire logic [14:0] ram_word_addr,
  input wire logic [1:0] ram_lane_we,
  input wire logic [15:0] ram_wdata,
  output logic [15:0] ram_rdata
);
  logic [15:0] mem [0:32767];
  // whole word read, shared word decode
  assign ram_rdata = mem[rd_addr[15:1]];
  // separate lane writes
  always_ff @(posedge sys_clk) begin
    if (ram_lane_we[0]) mem[ram_word_addr][7:0] <= ram_wdata[7:0];
    if (ram_lane_we[1]) mem[ram_word_addr][15:8] <= ram_wdata[15:8];
  end
endmodule : msd_mem_model

// >>> test/memory_space_address_decode_test.sv
/*
  memory_space_address_decode_test: self-checking bench for msd_decode.
  assumes msd_mem_model as the ram and the checker bound below.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
$display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module memory_space_address_decode_test;
  import msd_pkg::*;
  logic sys_clk, rst, clk_en, ip_advance, ip_retreat, ip_load, prog_upper_sel, in_vector_area;
  logic in_primary_table, in_alternate_table, near_direct_sel, dual_operand_dsp_class, y_rd_valid;
  logic pcr_hit, pcr_sel, psv_sel, in_near_space, x_space_hit, address_error_trap;
  logic [23:0] ip_load_addr, prog_fetch_addr, instruction_pointer, prog_word_addr, pf;
  logic [15:0] source_pointer_register, y_rd_addr, y_pointer, wreg_old, ram_rdata, y_ram_rdata;
  logic [15:0] pcr_rdata, psv_rdata, ram_wdata, x_rdata, y_rdata, wreg_new, x_ptr_next, y_ptr_next;
  logic [15:0] a, d, p;
  logic [14:0] ram_word_addr, y_ram_word_addr;
  logic [12:0] near_direct_field;
  logic [7:0] b;
  logic [1:0] ram_lane_we;
  msd_req_t x_req;
  msd_ptr_cfg_t x_cfg, y_cfg;
  msd_ptr_mode_t x_ptr_mode, y_ptr_mode;
  msd_ext_t ext_op;
  int n_mismatch, n_compared, cyc;
  msd_decode msd_decode_inst (.*);
  msd_mem_model msd_mem_model_inst (.sys_clk, .rd_addr(x_req.operand_byte_address),
    .ram_word_addr, .ram_lane_we, .ram_wdata, .ram_rdata);
  // expected {vector area, primary, alternate}
  function automatic logic [2:0] vexp(logic [23:0] x);
    return {x < 24'h000200, x >= 24'h000004 && x <= 24'h0000ff, x >= 24'h000100 && x <= 24'h0001ff};
  endfunction : vexp
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // one x request, answer looked at one edge later
  task automatic acc(input logic w, input logic bo, input logic [15:0] ad, input logic [15:0] wd);
    @(posedge sys_clk);
    p = 16'($urandom);
    x_req <= '{1'b1, w, bo, ad, wd};
    source_pointer_register <= p;
    wreg_old <= 16'($urandom);
    @(posedge sys_clk);
    #1;
    `CHK(x_ptr_next, p + (bo ? 16'h0001 : 16'h0002))
  endtask : acc
  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      conclude();
    end
  end
  // main sequence
  initial begin
    {clk_en, rst, ip_advance, ip_retreat, ip_load, near_direct_sel, pcr_hit} = 7'h60;
    {dual_operand_dsp_class, y_rd_valid, ip_load_addr, prog_fetch_addr, y_rd_addr} = '0;
    {source_pointer_register, y_pointer, wreg_old, y_ram_rdata, pcr_rdata, psv_rdata} = '0;
    {near_direct_field, x_req, x_cfg, y_cfg} = '0;
    {x_ptr_mode, y_ptr_mode, ext_op} = {MSD_PTR_INC, MSD_PTR_HOLD, MSD_EXT_NONE};
    void'($urandom(55025));
    repeat (20) @(posedge sys_clk);
    #1;
    `CHK(instruction_pointer, 24'h000000)
    @(posedge sys_clk);
    rst <= 1'b0;
    ip_load <= 1'b1;
    ip_load_addr <= 24'h000123;
    @(posedge sys_clk);
    @(posedge sys_clk);
    {ip_load, ip_advance} <= 2'b01;
    #1;
    `CHK(instruction_pointer, 24'h000122)
    @(posedge sys_clk);
    {ip_advance, ip_retreat} <= 2'b01;
    #1;
    `CHK(instruction_pointer, 24'h000124)
    @(posedge sys_clk);
    ip_retreat <= 1'b0;
    #1;
    `CHK(instruction_pointer, 24'h000122)
    $display("test pointer done");
    for (int i = 0; i < 14; i++) begin
      pf = i < 7 ? 24'h000200 - 24'(i * 83 + i / 6) : 24'($urandom) & 24'h0003ff;
      @(posedge sys_clk);
      prog_fetch_addr <= pf;
      @(posedge sys_clk);
      #1;
      `CHK({in_vector_area, in_primary_table, in_alternate_table}, vexp(pf))
      `CHK({prog_word_addr, prog_upper_sel}, {pf[23:1], 1'b0, pf[0]})
    end
    $display("test program map done");
    for (int i = 0; i < 16; i++) begin
      a = 16'h0800 + 16'($urandom % 28672);
      d = 16'($urandom);
      b = 8'($urandom);
      acc(1'b1, 1'b0, {a[15:1], 1'b0}, d);
      `CHK({ram_lane_we, address_error_trap}, 3'b110)
      acc(1'b1, 1'b1, a, {8'h00, b});
      `CHK({ram_lane_we, ram_wdata}, {a[0], !a[0], b, b})
      acc(1'b1, 1'b0, a | 16'h0001, 16'($urandom));
      `CHK({ram_lane_we, address_error_trap}, 3'b001)
      acc(1'b0, 1'b0, {a[15:1], 1'b0}, 16'h0000);
      `CHK(x_rdata, a[0] ? {b, d[7:0]} : {d[15:8], b})
      acc(1'b0, 1'b1, a, 16'h0000);
      `CHK({x_rdata, wreg_new}, {8'h00, b, wreg_old[15:8], b})
    end
    $display("test data lanes done");
    acc(1'b0, 1'b0, a | 16'h0001, 16'h0000);
    `CHK(address_error_trap, 1'b1)
    acc(1'b0, 1'b0, 16'h7800, 16'h0000);
    `CHK(x_rdata, 16'h0000)
    acc(1'b0, 1'b1, 16'h0101, 16'h0000);
    `CHK({x_rdata, pcr_sel, in_near_space}, {16'h0000, 2'b11})
    acc(1'b1, 1'b0, 16'h8002, 16'h1234);
    `CHK({psv_sel, ram_lane_we}, 3'b100)
    $display("test data map done");
    @(posedge sys_clk);
    {dual_operand_dsp_class, y_rd_valid, y_rd_addr, y_ram_rdata} <= {2'b11, 16'h5000, d};
    {ext_op, wreg_old} <= {MSD_EXT_SIGN, 16'h3480};
    @(posedge sys_clk);
    {dual_operand_dsp_class, ext_op} <= {1'b0, MSD_EXT_ZERO};
    #1;
    `CHK({y_rdata, wreg_new}, {d, 16'hff80})
    @(posedge sys_clk);
    #1;
    `CHK({y_rdata, wreg_new}, {16'h0000, 16'h0080})
    $display("test dual path done");
    // near direct field overrides the request address; circular and y pointer steps
    @(posedge sys_clk);
    near_direct_sel <= 1'b1;
    near_direct_field <= 13'h1ffe;
    x_req <= '{1'b1, 1'b0, 1'b0, 16'h8000, 16'h0000};
    x_ptr_mode <= MSD_PTR_DEC;
    source_pointer_register <= 16'h1000;
    x_cfg <= '{1'b1, 16'h1000, 16'h100f, 1'b0, 16'h0000};
    y_ptr_mode <= MSD_PTR_INC;
    y_pointer <= 16'h2000;
    @(posedge sys_clk);
    near_direct_sel <= 1'b0;
    {clk_en, ip_advance} <= 2'b01;
    #1;
    `CHK({in_near_space, psv_sel, x_space_hit, ram_word_addr}, {3'b101, 15'h0fff})
    `CHK({x_ptr_next, y_ptr_next, y_ram_word_addr}, {16'h100e, 16'h2002, 15'h2800})
    // clock enable low freezes the pointer despite an advance request
    @(posedge sys_clk);
    {clk_en, ip_advance} <= 2'b10;
    #1;
    `CHK(instruction_pointer, 24'h000122)
    $display("test near and pointer done");
    conclude();
  end
endmodule : memory_space_address_decode_test
bind msd_decode msd_decode_chk #(.RAM_END(RAM_END)) msd_decode_chk_inst (.sys_clk, .rst,
  .clk_en, .ip_advance, .ip_load, .prog_fetch_addr, .instruction_pointer, .in_vector_area,
  .x_req, .near_direct_sel, .dual_operand_dsp_class, .ram_word_addr, .ram_lane_we, .psv_sel,
  .x_rdata, .y_rdata, .address_error_trap);
